/* rtl/cqt_regs.sv */
// How it works
// - quiet-wait limit is 10 bits: high reg bits 1:0 upper, low reg lower eight
// - quiet period equals averaging period plus limit times 16 us
// - elapsed quiet time readable as 10 bits split over two read-only registers
// - elapsed value counts 16 us steps after the averaging period
// - 4-bit lead-in pattern resets to 0101, sent most significant bit first
// - select 0 routes out-of-range tuning onto the PLL unlock interrupt
// - above-upper status bit is 1 at or over the upper threshold
// - below-lower status bit is 1 under the lower threshold
// - averaging codes 0..5 give 1..32 averages, other codes give 16
`timescale 1ns/1ps
`default_nettype none

module cqt_regs #(
   parameter int STEP_CYCLES = cqt_pkg::STEP_CYCLES
) (
   input  wire logic        REF_CLK,
   input  wire logic        RESET,
   input  wire logic        CE,
   // register bus
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   // quiet judgement
   input  wire logic [2:0]  ENERGY_AVG_COUNT,
   input  wire logic        QUIET_START,
   input  wire logic        QUIET_ACTIVE,
   output var  logic        QUIET_EXPIRED,
   // lead-in serialiser
   input  wire logic        LEAD_IN_START,
   input  wire logic        LEAD_IN_STEP,
   output var  logic        LEAD_IN_BIT,
   // tuning comparators and interrupt
   input  wire logic        TUNE_ABOVE_UPPER,
   input  wire logic        TUNE_BELOW_LOWER,
   input  wire logic        PLL_UNLOCK,
   output var  logic        PLL_UNLOCK_INTERRUPT
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [5:0] avg_steps(input logic [2:0] code);
      logic [5:0] n;
      n = 6'h10;
      unique case (code)
         3'h0:    n = 6'h01;
         3'h1:    n = 6'h02;
         3'h2:    n = 6'h04;
         3'h3:    n = 6'h08;
         3'h4:    n = 6'h10;
         3'h5:    n = 6'h20;
         default: n = 6'h10;
      endcase
      return n;
   endfunction : avg_steps

   function automatic logic [31:0] byte_word(input logic [7:0] b);
      return {24'h000000, b};
   endfunction : byte_word

   // a register answers only on a word boundary inside the six-entry window
   function automatic logic addr_mapped(input logic [11:0] addr);
      logic [7:0] idx;
      idx = addr[cqt_pkg::ADDR_LSB +: 8];
      return (idx >= cqt_pkg::IDX_LIMIT_HIGH)
             && (idx <= cqt_pkg::IDX_VCO_STATUS)
             && (addr[11:10] == 2'h0)
             && (addr[1:0] == 2'h0);
   endfunction : addr_mapped

   // the judgement ends once the step count has met the wait limit
   function automatic logic limit_reached(input logic [cqt_pkg::CNT_W-1:0] count,
                                          input logic [cqt_pkg::CNT_W-1:0] limit);
      return count >= limit;
   endfunction : limit_reached

   function automatic logic [7:0] status_byte(input logic sel,
                                              input logic above,
                                              input logic below);
      logic [7:0] b;
      b = 8'h00;
      b[cqt_pkg::POS_SELECT] = sel;
      b[cqt_pkg::POS_ABOVE]  = above;
      b[cqt_pkg::POS_BELOW]  = below;
      return b;
   endfunction : status_byte

   localparam logic [11:0] STEP_LAST = 12'(STEP_CYCLES - 1);

   // ****************************************
   // state and decode
   // ****************************************
   cqt_pkg::cqt_state_t s_r;
   cqt_pkg::cqt_state_t s_nxt;

   logic [7:0] index;
   logic       access;
   logic       commit;
   logic       mapped;
   logic       step_tick;
   logic [7:0] rd_byte;
   logic [9:0] elapsed_inc;
   logic       out_of_range;

   assign index  = PADDR[cqt_pkg::ADDR_LSB +: 8];
   assign access = PSEL && PENABLE;
   // a write lands at the edge that completes the access
   assign commit       = access && s_r.pready && PWRITE && PSTRB[0];
   assign mapped       = addr_mapped(PADDR);
   assign step_tick    = (s_r.step_cnt == STEP_LAST);
   assign elapsed_inc  = 10'(s_r.elapsed + 10'h001);
   assign out_of_range = s_r.vco.above || s_r.vco.below;

   // ****************************************
   // read decode
   // ****************************************
   always_comb begin
      rd_byte = 8'h00;
      unique case (index)
         cqt_pkg::IDX_LIMIT_HIGH: begin
            rd_byte = {6'h00, s_r.limit[9:8]};
         end
         cqt_pkg::IDX_LIMIT_LOW: begin
            rd_byte = s_r.limit[7:0];
         end
         cqt_pkg::IDX_ELAPSED_HIGH: begin
            rd_byte = {6'h00, s_r.elapsed[9:8]};
         end
         cqt_pkg::IDX_ELAPSED_LOW: begin
            rd_byte = s_r.elapsed[7:0];
         end
         cqt_pkg::IDX_PATTERN: begin
            rd_byte = {4'h0, s_r.pattern};
         end
         cqt_pkg::IDX_VCO_STATUS: begin
            // comparator bits come from the synchronised levels
            rd_byte = status_byte(s_r.irq_select, s_r.vco.above, s_r.vco.below);
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;

      // ****************************************
      // pin levels pass two flops
      // ****************************************
      s_nxt.vco_meta.above  = TUNE_ABOVE_UPPER;
      s_nxt.vco_meta.below  = TUNE_BELOW_LOWER;
      s_nxt.vco_meta.unlock = PLL_UNLOCK;
      s_nxt.vco             = s_r.vco_meta;

      // ****************************************
      // apb: one wait state, write commits on the pready edge
      // ****************************************
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (access && !s_r.pready) begin
         s_nxt.pready  = 1'b1;
         s_nxt.pslverr = !mapped;
         if (mapped && !PWRITE) begin
            s_nxt.prdata = byte_word(rd_byte);
         end else begin
            // refused or write access: the bus reads zero
            s_nxt.prdata = 32'h00000000;
         end
      end
      if (commit && mapped) begin
         unique case (index)
            cqt_pkg::IDX_LIMIT_HIGH: begin
               s_nxt.limit[9:8] = PWDATA[1:0];
            end
            cqt_pkg::IDX_LIMIT_LOW: begin
               s_nxt.limit[7:0] = PWDATA[7:0];
            end
            cqt_pkg::IDX_ELAPSED_HIGH, cqt_pkg::IDX_ELAPSED_LOW: begin
               // read-only count: a write leaves it alone
               s_nxt.elapsed = s_r.elapsed;
            end
            cqt_pkg::IDX_PATTERN: begin
               s_nxt.pattern = PWDATA[3:0];
            end
            cqt_pkg::IDX_VCO_STATUS: begin
               s_nxt.irq_select = PWDATA[cqt_pkg::POS_SELECT];
            end
            default: begin
               s_nxt.limit = s_r.limit;
            end
         endcase
      end

      // ****************************************
      // quiet judgement timing
      // ****************************************
      s_nxt.expired = 1'b0;
      if (step_tick) begin
         s_nxt.step_cnt = 12'h000;
      end else begin
         s_nxt.step_cnt = 12'(s_r.step_cnt + 12'h001);
      end
      unique case (s_r.quiet)
         cqt_pkg::Q_IDLE: begin
            s_nxt.step_cnt = 12'h000;
         end
         cqt_pkg::Q_AVERAGE: begin
            if (step_tick) begin
               s_nxt.avg_left = 6'(s_r.avg_left - 6'h01);
               if (s_r.avg_left == 6'h01) begin
                  if (limit_reached(10'h000, s_r.limit)) begin
                     s_nxt.quiet   = cqt_pkg::Q_EXPIRED;
                     s_nxt.expired = 1'b1;
                  end else begin
                     s_nxt.quiet = cqt_pkg::Q_COUNT;
                  end
               end
            end
         end
         cqt_pkg::Q_COUNT: begin
            if (step_tick) begin
               s_nxt.elapsed = elapsed_inc;
               if (limit_reached(elapsed_inc, s_r.limit)) begin
                  s_nxt.quiet   = cqt_pkg::Q_EXPIRED;
                  s_nxt.expired = 1'b1;
               end
            end
         end
         cqt_pkg::Q_EXPIRED: begin
            s_nxt.step_cnt = 12'h000;
         end
      endcase
      if (!QUIET_ACTIVE) begin
         s_nxt.quiet = cqt_pkg::Q_IDLE;
      end
      // a new start wins over an abort in the same cycle
      if (QUIET_START) begin
         s_nxt.quiet    = cqt_pkg::Q_AVERAGE;
         s_nxt.step_cnt = 12'h000;
         s_nxt.avg_left = avg_steps(ENERGY_AVG_COUNT);
         s_nxt.elapsed  = 10'h000;
         s_nxt.expired  = 1'b0;
      end

      // ****************************************
      // lead-in serialiser, msb first
      // ****************************************
      if (LEAD_IN_START) begin
         s_nxt.bit_idx = 2'h2;
         s_nxt.pre_bit = s_r.pattern[3];
      end else if (LEAD_IN_STEP) begin
         s_nxt.bit_idx = 2'(s_r.bit_idx - 2'h1);
         s_nxt.pre_bit = s_r.pattern[s_r.bit_idx];
      end

      // ****************************************
      // unlock interrupt routing
      // ****************************************
      unique case (s_r.irq_select)
         1'b0: begin
            // out-of-range tuning shares the unlock interrupt
            s_nxt.irq = s_r.vco.unlock || out_of_range;
         end
         1'b1: begin
            // out-of-range only shows in the status bits
            s_nxt.irq = s_r.vco.unlock;
         end
      endcase
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         s_r            <= '0;
         s_r.limit      <= cqt_pkg::LIMIT_RESET;
         s_r.pattern    <= cqt_pkg::PATTERN_RESET;
         s_r.quiet      <= cqt_pkg::Q_IDLE;
         s_r.bit_idx    <= 2'h3;
      end else if (CE) begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign PRDATA               = s_r.prdata;
   assign PREADY               = s_r.pready;
   assign PSLVERR              = s_r.pslverr;
   assign QUIET_EXPIRED        = s_r.expired;
   assign LEAD_IN_BIT          = s_r.pre_bit;
   assign PLL_UNLOCK_INTERRUPT = s_r.irq;

endmodule : cqt_regs

`default_nettype wire

/* shared/cqt_pkg.sv */
package cqt_pkg;

   // ****************************************
   // register indexes (byte address = 4 * index)
   // ****************************************
   localparam logic [7:0] IDX_LIMIT_HIGH   = 8'h3b;
   localparam logic [7:0] IDX_LIMIT_LOW    = 8'h3c;
   localparam logic [7:0] IDX_ELAPSED_HIGH = 8'h3d;
   localparam logic [7:0] IDX_ELAPSED_LOW  = 8'h3e;
   localparam logic [7:0] IDX_PATTERN      = 8'h3f;
   localparam logic [7:0] IDX_VCO_STATUS   = 8'h40;
   localparam int         ADDR_LSB         = 2;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int         CNT_W            = 10;
   localparam int         PAT_W            = 4;
   localparam int         POS_SELECT       = 2;
   localparam int         POS_ABOVE        = 1;
   localparam int         POS_BELOW        = 0;
   localparam logic [9:0] LIMIT_RESET      = 10'h000;
   localparam logic [3:0] PATTERN_RESET    = 4'h5;

   // ****************************************
   // timing
   // ****************************************
   localparam int         CLK_MHZ          = 125;
   localparam int         STEP_US          = 16;
   localparam int         STEP_CYCLES      = STEP_US * CLK_MHZ;
   localparam int         STEP_W           = 12;

   typedef enum logic [1:0] {
      Q_IDLE,
      Q_AVERAGE,
      Q_COUNT,
      Q_EXPIRED
   } cqt_quiet_t;

   // synchronised comparator and unlock levels
   typedef struct packed {
      logic above;
      logic below;
      logic unlock;
   } cqt_vco_t;

   typedef struct packed {
      cqt_vco_t             vco_meta;
      cqt_vco_t             vco;
      logic [CNT_W-1:0]     limit;
      logic [PAT_W-1:0]     pattern;
      logic                 irq_select;
      cqt_quiet_t           quiet;
      logic [STEP_W-1:0]    step_cnt;
      logic [5:0]           avg_left;
      logic [CNT_W-1:0]     elapsed;
      logic                 expired;
      logic [1:0]           bit_idx;
      logic                 pre_bit;
      logic                 irq;
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
   } cqt_state_t;

endpackage : cqt_pkg

/* verification/cqt_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module cqt_regs_chk (
   input wire logic        REF_CLK,
   input wire logic        RESET,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        QUIET_EXPIRED,
   input wire logic        TUNE_ABOVE_UPPER,
   input wire logic        TUNE_BELOW_LOWER,
   input wire logic        PLL_UNLOCK,
   input wire logic        PLL_UNLOCK_INTERRUPT
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   logic acc;
   logic bad;
   assign acc = PSEL && PENABLE && !PREADY;
   assign bad = PADDR[1:0] != 2'h0 || PADDR[11:2] < 10'h03b || PADDR[11:2] > 10'h040;
   a_ready_one_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("no answer after one wait");
   a_ready_single: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
   a_err_unmapped: assert property (acc && bad |=> PSLVERR && PRDATA == 32'h0) else $error("bad address not refused");
   a_ok_mapped: assert property (acc && !bad |=> !PSLVERR) else $error("good address refused");
   a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
   a_expired_pulse: assert property (QUIET_EXPIRED |=> !QUIET_EXPIRED) else $error("expiry not a pulse");
   a_irq_unlock: assert property (PLL_UNLOCK [*4] |=> PLL_UNLOCK_INTERRUPT) else $error("unlock not raised");
   a_irq_quiet: assert property ((!PLL_UNLOCK && !TUNE_ABOVE_UPPER && !TUNE_BELOW_LOWER) [*4]
      |=> !PLL_UNLOCK_INTERRUPT) else $error("interrupt without cause");
   cover property (QUIET_EXPIRED);
   cover property (PREADY && PSLVERR);
   cover property (PLL_UNLOCK_INTERRUPT);
endmodule : cqt_regs_chk
bind cqt_regs cqt_regs_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .QUIET_EXPIRED(QUIET_EXPIRED),
   .TUNE_ABOVE_UPPER(TUNE_ABOVE_UPPER), .TUNE_BELOW_LOWER(TUNE_BELOW_LOWER), .PLL_UNLOCK(PLL_UNLOCK),
   .PLL_UNLOCK_INTERRUPT(PLL_UNLOCK_INTERRUPT));
`default_nettype wire

/* verification/tb_cca_quiet_timing_vco_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cca_quiet_timing_vco_status_regs;
   localparam int S = 4;
   logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, en = 1'b0, wr = 1'b0, qs = 1'b0, qa = 1'b0;
   logic        ls = 1'b0, lst = 1'b0, ab = 1'b0, be = 1'b0, ul = 1'b0, ce = 1'b1;
   logic [11:0] adr = 12'h0;
   logic [31:0] wd = 32'h0, rd, got;
   logic [2:0]  avg = 3'h0;
   logic        rdy, err, qx, lb, irq, gerr;
   int          n_errors = 0, checks_done = 0, cyc = 0, n;
   int          avgs [8] = '{1, 2, 4, 8, 16, 32, 16, 16};
   logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00};
   cqt_regs #(.STEP_CYCLES(S)) dut (.REF_CLK(clk), .RESET(rst), .CE(ce), .PSEL(sel), .PENABLE(en),
      .PWRITE(wr), .PADDR(adr), .PWDATA(wd), .PSTRB(4'h1), .PRDATA(rd), .PREADY(rdy), .PSLVERR(err),
      .ENERGY_AVG_COUNT(avg), .QUIET_START(qs), .QUIET_ACTIVE(qa), .QUIET_EXPIRED(qx),
      .LEAD_IN_START(ls), .LEAD_IN_STEP(lst), .LEAD_IN_BIT(lb), .TUNE_ABOVE_UPPER(ab),
      .TUNE_BELOW_LOWER(be), .PLL_UNLOCK(ul), .PLL_UNLOCK_INTERRUPT(irq));
   always #4 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      en <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      got = rd;
      gerr = err;
      sel <= 1'b0;
      en <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(got | {gerr, 31'h0}, e);
   endtask : rchk
   task automatic give_verdict;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) rchk(12'(4 * (cqt_pkg::IDX_LIMIT_HIGH + i)), 32'(rv[i]));
      apb(1'b1, 12'h0ec, 32'hff);
      rchk(12'h0ec, 32'h3);
      apb(1'b1, 12'h0f8, 32'hff);
      rchk(12'h0f8, 32'h0);
      rchk(12'h104, 32'h80000000);
      rchk(12'h0ed, 32'h80000000);
      apb(1'b1, 12'h0ec, 32'h0);
      apb(1'b1, 12'h0f0, 32'h3);
      rchk(12'h0f0, 32'h3);
      qa <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         avg <= 3'(c);
         @(posedge clk);
         qs <= 1'b1;
         @(posedge clk);
         qs <= 1'b0;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (qx !== 1'b1 && n < 400);
         chk(n, (avgs[c] + 3) * S + 1);
         rchk(12'h0f8, 32'h3);
         rchk(12'h0f4, 32'h0);
      end
      qs <= 1'b1;
      @(posedge clk);
      qs <= 1'b0;
      rchk(12'h0f8, 32'h0);
      qa <= 1'b0;
      apb(1'b1, 12'h0fc, 32'ha);
      rchk(12'h0fc, 32'ha);
      ls <= 1'b1;
      @(posedge clk);
      ls <= 1'b0;
      for (int i = 3; i >= 0; i--) begin
         @(posedge clk);
         chk(32'(lb), 32'((4'ha >> i) & 4'h1));
         lst <= 1'b1;
         @(posedge clk);
         lst <= 1'b0;
      end
      // a step while disabled must not advance the lead-in bit
      @(posedge clk);
      ce <= 1'b0;
      lst <= 1'b1;
      @(posedge clk);
      lst <= 1'b0;
      ce <= 1'b1;
      @(posedge clk);
      chk(32'(lb), 32'h1);
      ab <= 1'b1;
      rchk(12'h100, 32'h2);
      chk(32'(irq), 32'h1);
      ab <= 1'b0;
      be <= 1'b1;
      rchk(12'h100, 32'h1);
      apb(1'b1, 12'h100, 32'h4);
      rchk(12'h100, 32'h5);
      chk(32'(irq), 32'h0);
      ul <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(irq), 32'h1);
      give_verdict();
   end
endmodule : tb_cca_quiet_timing_vco_status_regs
`default_nettype wire
